// File: rtl/periodic_int_microframe_sched.sv
/*
  Interrupt transfer microframe scheduler: schedule mask, per-microframe
  results, microframe zero byte count, interrupt, AXI4-Lite registers.
  Assumes a bus engine that reports each issued transaction once.
*/
`timescale 1ns/10ps
`include "uframe_sched_cfg.svh"

module periodic_int_microframe_sched
  import uframe_sched_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic [`ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    sofPulse,
  input  wire logic [`FRAME_W-1:0]     busFrame,
  input  wire logic [2:0]              busUframe,
  input  uframe_sched_pkg::txn_done_t  txnDone,
  output uframe_sched_pkg::txn_req_t   txnReq,
  output logic                         irq
);
  import uframe_sched_pkg::*;

  localparam int RES_TOTAL = `RESULT_W * `NUM_UFRAMES;

  // Register state
  logic [`FRAME_W-1:0]       frameField_q, frameField_d;
  logic [`NUM_UFRAMES-1:0]   schedMask_q, schedMask_d;
  logic [RES_TOTAL-1:0]      results_q, results_d;
  logic [`COUNT_W-1:0]       countZero_q, countZero_d;
  logic [`IRQ_W-1:0]         irqStatus_q, irqStatus_d;
  logic [`IRQ_W-1:0]         irqEnable_q, irqEnable_d;
  logic                      irq_d;

  // Bus side handshake results
  logic                      wrEn;
  logic [`ADDR_W-1:0]        wrAddr;
  logic [31:0]               wrData;
  logic [3:0]                wrStrb;
  logic [31:0]               rdWord;
  logic                      rdHit;
  logic                      wrHit;

  logic                      schedBusy;
  logic                      doneSeen;
  logic [`RESULT_W-1:0]      newResult;
  logic [`NUM_UFRAMES-1:0]   armBits;
  logic [`IRQ_W-1:0]         irqEvents;
  logic [`IRQ_W-1:0]         irqClear;
  logic [31:0]               mergedWord;
  logic [31:0]               enableMerged;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] strobeMerge(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldWord;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newWord[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address decode shared by the read and write sides
  function automatic logic isMapped(input logic [`ADDR_W-1:0] a);
    return (a == `ADDR_DESC_TWO)   || (a == `ADDR_DESC_FOUR) ||
           (a == `ADDR_COUNT_ZERO) || (a == `ADDR_IRQ_STATUS) ||
           (a == `ADDR_IRQ_ENABLE) || (a == `ADDR_IRQ_CLEAR);
  endfunction

  axi_lite_regs_slave u_bus (
    .core_clk (core_clk),
    .reset    (reset),
    .awaddr   (s_axi_awaddr),
    .awvalid  (s_axi_awvalid),
    .awready  (s_axi_awready),
    .wdata    (s_axi_wdata),
    .wstrb    (s_axi_wstrb),
    .wvalid   (s_axi_wvalid),
    .wready   (s_axi_wready),
    .bresp    (s_axi_bresp),
    .bvalid   (s_axi_bvalid),
    .bready   (s_axi_bready),
    .araddr   (s_axi_araddr),
    .arvalid  (s_axi_arvalid),
    .arready  (s_axi_arready),
    .rdata    (s_axi_rdata),
    .rresp    (s_axi_rresp),
    .rvalid   (s_axi_rvalid),
    .rready   (s_axi_rready),
    .rdWord   (rdWord),
    .rdHit    (rdHit),
    .wrHit    (wrHit),
    .wrEn     (wrEn),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrStrb   (wrStrb)
  );

  uframe_issue_sched u_sched (
    .core_clk   (core_clk),
    .reset      (reset),
    .sofPulse   (sofPulse),
    .busFrame   (busFrame),
    .busUframe  (busUframe),
    .frameField (frameField_q),
    .schedMask  (schedMask_q),
    .doneSeen   (doneSeen),
    .txnReq     (txnReq),
    .busy       (schedBusy)
  );

  // Reports arriving while nothing is outstanding are dropped
  assign doneSeen = txnDone.valid && schedBusy;

  // Write decode is against the address held by the slave
  assign wrHit = isMapped(wrAddr);
  assign rdHit = isMapped(s_axi_araddr);

  // Flags that do not apply to the token direction are masked off
  assign newResult[0] = txnDone.flags.txErr;
  assign newResult[1] = txnDone.flags.babble && txnDone.isIn;
  assign newResult[2] = txnDone.flags.underrun && !txnDone.isIn;

  assign irqEvents[`IRQ_DONE]  = doneSeen;
  assign irqEvents[`IRQ_ERROR] = doneSeen && (newResult != '0);

  // Read mux
  always_comb begin
    rdWord = `ZERO_WORD;
    case (s_axi_araddr)
      `ADDR_DESC_TWO: begin
        rdWord[`FRAME_LSB +: `FRAME_W] = frameField_q;
      end
      `ADDR_DESC_FOUR: begin
        rdWord[`RESULT_LSB +: RES_TOTAL] = results_q;
        rdWord[`NUM_UFRAMES-1:0]         = schedMask_q;
      end
      `ADDR_COUNT_ZERO: rdWord[`COUNT_W-1:0] = countZero_q;
      `ADDR_IRQ_STATUS: rdWord[`IRQ_W-1:0]   = irqStatus_q;
      `ADDR_IRQ_ENABLE: rdWord[`IRQ_W-1:0]   = irqEnable_q;
      default:          rdWord = `ZERO_WORD;
    endcase
  end

  // Software side decode of the descriptor and interrupt registers
  always_comb begin
    mergedWord   = strobeMerge(`ZERO_WORD, wrData, wrStrb);
    enableMerged = strobeMerge({30'h0000_0000, irqEnable_q}, wrData, wrStrb);
    frameField_d = frameField_q;
    irqEnable_d  = irqEnable_q;
    armBits      = '0;
    irqClear     = '0;
    if (wrEn) begin
      case (wrAddr)
        `ADDR_DESC_TWO: begin
          if (wrStrb[0]) begin
            frameField_d = wrData[`FRAME_LSB +: `FRAME_W];
          end
        end
        `ADDR_DESC_FOUR: armBits = mergedWord[`NUM_UFRAMES-1:0];
        `ADDR_IRQ_ENABLE: begin
          irqEnable_d = enableMerged[`IRQ_W-1:0];
        end
        `ADDR_IRQ_CLEAR: irqClear = mergedWord[`IRQ_W-1:0];
        default: begin
          armBits  = '0;
          irqClear = '0;
        end
      endcase
    end
  end

  // Hardware side: schedule mask, results and microframe zero count
  always_comb begin
    schedMask_d = schedMask_q;
    results_d   = results_q;
    countZero_d = countZero_q;
    if (doneSeen) begin
      results_d[txnDone.uframe*`RESULT_W +: `RESULT_W] = newResult;
      schedMask_d[txnDone.uframe] = 1'b0;
      if (txnDone.uframe == '0 && txnDone.isIn && schedMask_q[0]) begin
        countZero_d = txnDone.count;
      end
    end
    // Writing 1 arms a bit, writing 0 leaves it; an arm beats a clear
    schedMask_d = schedMask_d | armBits;
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_comb begin
    irqStatus_d = (irqStatus_q & ~irqClear) | irqEvents;
    irq_d       = |(irqStatus_d & irqEnable_d);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      frameField_q <= '0;
      schedMask_q  <= '0;
      results_q    <= '0;
      countZero_q  <= '0;
      irqStatus_q  <= '0;
      irqEnable_q  <= '0;
      irq          <= 1'b0;
    end else begin
      frameField_q <= frameField_d;
      schedMask_q  <= schedMask_d;
      results_q    <= results_d;
      countZero_q  <= countZero_d;
      irqStatus_q  <= irqStatus_d;
      irqEnable_q  <= irqEnable_d;
      irq          <= irq_d;
    end
  end
endmodule

// File: inc/uframe_sched_cfg.svh
/*
  Address map, field positions and response codes of the interrupt
  microframe scheduler. Assumes inclusion by bare name from rtl files.
*/
`ifndef UFRAME_SCHED_CFG_SVH
`define UFRAME_SCHED_CFG_SVH

`define ADDR_W          8
`define ADDR_DESC_TWO   8'h00
`define ADDR_DESC_FOUR  8'h04
`define ADDR_COUNT_ZERO 8'h08
`define ADDR_IRQ_STATUS 8'h0C
`define ADDR_IRQ_ENABLE 8'h10
`define ADDR_IRQ_CLEAR  8'h14

`define FRAME_LSB       3
`define FRAME_W         5
`define RESULT_LSB      8
`define RESULT_W        3
`define NUM_UFRAMES     8
`define COUNT_W         12
`define IRQ_W           2
`define IRQ_DONE        0
`define IRQ_ERROR       1

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define ZERO_WORD       32'h0000_0000

`endif

// File: inc/uframe_sched_pkg.sv
/*
  Types shared by the microframe scheduler blocks.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uframe_sched_pkg;

  // Outcome flags of one interrupt transaction
  typedef struct packed {
    logic underrun;
    logic babble;
    logic txErr;
  } txn_flags_t;

  // Completion report from the bus engine
  typedef struct packed {
    logic       valid;
    logic [2:0] uframe;
    logic       isIn;
    txn_flags_t flags;
    logic [11:0] count;
  } txn_done_t;

  // Transaction request to the bus engine
  typedef struct packed {
    logic       valid;
    logic [2:0] uframe;
  } txn_req_t;

  typedef enum logic [0:0] {
    SCHED_IDLE = 1'b0,
    SCHED_WAIT = 1'b1
  } sched_state_t;

endpackage

// File: rtl/axi_lite_regs_slave.sv
/*
  AXI4-Lite slave front end: one read in flight; a second write is held while a write response waits.
  Assumes the owner supplies read data for araddr combinationally.
*/
`timescale 1ns/10ps
`include "uframe_sched_cfg.svh"

module axi_lite_regs_slave (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [`ADDR_W-1:0]   awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [`ADDR_W-1:0]   araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [31:0]          rdWord,
  input  wire logic                 rdHit,
  input  wire logic                 wrHit,
  output logic                      wrEn,
  output logic [`ADDR_W-1:0]        wrAddr,
  output logic [31:0]               wrData,
  output logic [3:0]                wrStrb
);
  logic                awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic                bvalid_d, rvalid_d, wrEn_d;
  logic [1:0]          bresp_d, rresp_d;
  logic [31:0]         rdata_d, wrData_d;
  logic [3:0]          wrStrb_d;
  logic [`ADDR_W-1:0]  wrAddr_d;
  logic                awTake, wTake, arTake;

  // Each channel is ready only while it holds nothing, so a payload is never overwritten
  assign awready = !awHeld_q && !reset;
  assign wready  = !wHeld_q && !reset;
  assign arready = !rvalid && !reset;
  assign awTake  = awvalid && awready;
  assign wTake   = wvalid && wready;
  assign arTake  = arvalid && arready;

  always_comb begin
    awHeld_d = awHeld_q || awTake;
    wHeld_d  = wHeld_q || wTake;
    wrAddr_d = awTake ? awaddr : wrAddr;
    wrData_d = wTake ? wdata : wrData;
    wrStrb_d = wTake ? wstrb : wrStrb;
    wrEn_d   = 1'b0;
    bvalid_d = bvalid && !bready;
    bresp_d  = bresp;
    if (awHeld_q && wHeld_q && !bvalid) begin
      wrEn_d   = wrHit;
      bvalid_d = 1'b1;
      bresp_d  = wrHit ? `RESP_OKAY : `RESP_SLVERR;
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
    end
    rvalid_d = rvalid && !rready;
    rdata_d  = rdata;
    rresp_d  = rresp;
    if (arTake) begin
      rvalid_d = 1'b1;
      rdata_d  = rdHit ? rdWord : `ZERO_WORD;
      rresp_d  = rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      wrEn     <= 1'b0;
      wrAddr   <= '0;
      wrData   <= `ZERO_WORD;
      wrStrb   <= '0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
      rvalid   <= 1'b0;
      rdata    <= `ZERO_WORD;
      rresp    <= `RESP_OKAY;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      wrEn     <= wrEn_d;
      wrAddr   <= wrAddr_d;
      wrData   <= wrData_d;
      wrStrb   <= wrStrb_d;
      bvalid   <= bvalid_d;
      bresp    <= bresp_d;
      rvalid   <= rvalid_d;
      rdata    <= rdata_d;
      rresp    <= rresp_d;
    end
  end
endmodule

// File: rtl/uframe_issue_sched.sv
/*
  Decides at each microframe start whether an interrupt transaction
  is issued. Assumes sofPulse is one cycle wide per microframe.
*/
`timescale 1ns/10ps
`include "uframe_sched_cfg.svh"

module uframe_issue_sched
  import uframe_sched_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      sofPulse,
  input  wire logic [`FRAME_W-1:0]       busFrame,
  input  wire logic [2:0]                busUframe,
  input  wire logic [`FRAME_W-1:0]       frameField,
  input  wire logic [`NUM_UFRAMES-1:0]   schedMask,
  input  wire logic                      doneSeen,
  output uframe_sched_pkg::txn_req_t     txnReq,
  output logic                           busy
);
  sched_state_t state_q, state_d;
  txn_req_t     req_d;
  logic         frameMatch;

  // A zero frame field marks sub-millisecond polling: mask alone decides
  assign frameMatch = (frameField == busFrame) || (frameField == '0);
  assign busy       = (state_q == SCHED_WAIT);

  always_comb begin
    state_d      = state_q;
    req_d.valid  = 1'b0;
    req_d.uframe = txnReq.uframe;
    case (state_q)
      SCHED_IDLE: begin
        if (sofPulse && frameMatch && schedMask[busUframe]) begin
          req_d.valid  = 1'b1;
          req_d.uframe = busUframe;
          state_d      = SCHED_WAIT;
        end
      end
      SCHED_WAIT: begin
        if (doneSeen) begin
          state_d = SCHED_IDLE;
        end
      end
      default: state_d = SCHED_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= SCHED_IDLE;
      txnReq  <= '0;
    end else begin
      state_q <= state_d;
      txnReq  <= req_d;
    end
  end
endmodule

// File: testbench/usb_int_endpoint_model.sv
/*
  Behavioural bus engine with downstream interrupt endpoints: answers each
  request once, quickly for low microframes and slowly for high ones.
  Assumes one request outstanding at a time, as the scheduler promises.
*/
`timescale 1ns/10ps

module usb_int_endpoint_model
  import uframe_sched_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  uframe_sched_pkg::txn_req_t  txnReq,
  output uframe_sched_pkg::txn_done_t txnDone
);
  logic       pend_q;
  logic [2:0] uf_q;
  int         wait_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_q  <= 1'b0;
      txnDone <= '0;
    end else begin
      // Stale count and flags keep moving so nothing can rely on them outside valid
      txnDone.valid <= 1'b0;
      txnDone.count <= ~txnDone.count;
      txnDone.flags <= ~txnDone.flags;
      if (txnReq.valid) begin
        pend_q <= 1'b1;
        uf_q   <= txnReq.uframe;
        wait_q <= 1 + 3 * txnReq.uframe;
      end else if (pend_q && wait_q > 0) begin
        wait_q <= wait_q - 1;
      end else if (pend_q) begin
        // Low half IN with error and babble, high half OUT with underrun
        pend_q  <= 1'b0;
        txnDone <= '{1'b1, uf_q, ~uf_q[2], (uf_q[2] ? 3'b100 : 3'b011), (12'hAA0 | uf_q)};
      end
    end
  end
endmodule

// File: testbench/sched_port_checker.sv
/*
  Port-level assertions of the microframe scheduler.
  Assumes binding into the top module, connected by port name.
*/
`timescale 1ns/10ps

module sched_port_checker
  import uframe_sched_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   s_axi_arvalid,
  input  wire logic                   s_axi_arready,
  input  wire logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [1:0]             s_axi_bresp,
  input  wire logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   sofPulse,
  input  wire logic [2:0]             busUframe,
  input  uframe_sched_pkg::txn_done_t txnDone,
  input  uframe_sched_pkg::txn_req_t  txnReq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  logic outstanding_q;

  always_ff @(posedge core_clk) begin
    if (reset) outstanding_q <= 1'b0;
    else if (txnReq.valid) outstanding_q <= 1'b1;
    else if (txnDone.valid) outstanding_q <= 1'b0;
  end

  chk_req_cause: assert property (
    txnReq.valid |-> $past(sofPulse) && txnReq.uframe == $past(busUframe))
    else $error("request without matching microframe start");
  chk_req_pulse: assert property (
    txnReq.valid |=> !txnReq.valid) else $error("request longer than one cycle");
  chk_one_outstanding: assert property (
    txnReq.valid |-> !outstanding_q) else $error("second request before completion");
  chk_sof_busy: assert property (
    outstanding_q && !txnDone.valid && sofPulse |=> !txnReq.valid)
    else $error("microframe start taken while busy");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while answering");
  chk_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_r_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
endmodule

// File: testbench/test_periodic_int_microframe_sched.sv
/*
  Self-checking bench of the microframe scheduler: register bus, sweeps of
  schedule masks, frame gating and interrupt path.
  Assumes the endpoint model and the checker are compiled before it.
*/
`timescale 1ns/10ps
`include "uframe_sched_cfg.svh"

module test_periodic_int_microframe_sched;
  import uframe_sched_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sofPulse = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  busFrame = '0;
  logic [2:0]  busUframe = '0;
  logic [7:0]  reqSeen;
  logic [31:0] resWord = '0;
  txn_done_t   txnDone;
  txn_req_t    txnReq;
  int          miscompares = 0;
  int          samplesChecked = 0;

  always #5 core_clk = ~core_clk;

  periodic_int_microframe_sched u_dut (.*);
  usb_int_endpoint_model u_eng (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic stall();
    miscompares++;
    report_and_stop();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) stall();
    check(s_axi_bresp, er);
    // One edge between transfers so bready is never driven twice at once
    @(posedge core_clk);
  endtask

  // Compares only the bits under the mask, so fields owned elsewhere are ignored
  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er = `RESP_OKAY, input logic [31:0] m = '1);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) stall();
    check(s_axi_rdata & m, exp);
    check(s_axi_rresp, er);
    @(posedge core_clk);
  endtask

  task automatic run_uframe(input logic [4:0] fr, input logic [2:0] uf);
    int n;
    n = 0;
    busFrame <= fr;
    busUframe <= uf;
    sofPulse <= 1'b1;
    @(posedge core_clk);
    sofPulse <= 1'b0;
    @(posedge core_clk);
    if (txnReq.valid === 1'b1) begin
      reqSeen[uf] = 1'b1;
      do begin
        @(posedge core_clk);
        n++;
        // A microframe start while busy must be ignored
        sofPulse <= (n == 1);
      end while (txnDone.valid !== 1'b1 && n < 40);
      if (n >= 40) stall();
      repeat (2) @(posedge core_clk);
    end
  endtask

  task automatic reset_values();
    axi_read(`ADDR_DESC_FOUR, 32'h0);
    axi_read(`ADDR_COUNT_ZERO, 32'h0);
    axi_read(`ADDR_IRQ_STATUS, 32'h0);
    check(irq, 32'h0);
  endtask

  task automatic sweep(input logic [7:0] mask);
    reqSeen = 8'h00;
    axi_write(`ADDR_DESC_FOUR, {24'h0, mask});
    for (int u = 0; u < 8; u++) begin
      run_uframe(5'd3, u[2:0]);
      if (mask[u]) resWord[8 + 3 * u +: 3] = u[2] ? 3'b100 : 3'b011;
    end
    check(reqSeen, mask);
    axi_read(`ADDR_DESC_FOUR, resWord);
    axi_read(`ADDR_COUNT_ZERO, 32'hAA0);
  endtask

  task automatic frame_gate();
    axi_write(`ADDR_DESC_TWO, 32'h28);
    axi_write(`ADDR_DESC_FOUR, 32'h02);
    axi_write(`ADDR_DESC_FOUR, 32'h00);
    axi_read(`ADDR_DESC_FOUR, 32'h02, `RESP_OKAY, 32'hFF);
    reqSeen = 8'h00;
    run_uframe(5'd6, 3'd1);
    check(reqSeen, 8'h00);
    axi_read(`ADDR_DESC_FOUR, 32'h02, `RESP_OKAY, 32'hFF);
    run_uframe(5'd5, 3'd1);
    check(reqSeen, 8'h02);
    axi_read(`ADDR_DESC_FOUR, resWord);
  endtask

  task automatic irq_path();
    axi_read(`ADDR_IRQ_STATUS, 32'h3);
    check(irq, 32'h0);
    axi_write(`ADDR_IRQ_ENABLE, 32'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 32'h1);
    axi_write(`ADDR_IRQ_CLEAR, 32'h1);
    repeat (3) @(posedge core_clk);
    check(irq, 32'h0);
    axi_read(`ADDR_IRQ_STATUS, 32'h2);
    axi_read(`ADDR_IRQ_CLEAR, 32'h0);
    axi_read(8'h40, 32'h0, `RESP_SLVERR);
    axi_write(8'h40, 32'h1, `RESP_SLVERR);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    reset_values();
    // Frame field zero: sub-millisecond polling, the mask decides
    axi_write(`ADDR_DESC_TWO, 32'h0);
    sweep(8'h11);
    sweep(8'h55);
    sweep(8'hFF);
    frame_gate();
    irq_path();
    report_and_stop();
  end
endmodule

bind periodic_int_microframe_sched sched_port_checker u_chk (.*);
